/* File: rtl/rfbank_pkg.sv */
// Purpose: Constants for the register file bank addressing block.
// Assumes: 256-byte register file, one 200 MHz clock.
// Notes: Offsets are register addresses as seen by the core.
package rfbank_pkg;
  localparam int RFBANK_CLK_MHZ = 200;
  // Core addressing modes.
  typedef enum logic [1:0] {
    RFBANK_MODE_DIRECT = 2'h0,
    RFBANK_MODE_INDIRECT = 2'h1,
    RFBANK_MODE_WORKING = 2'h3
  } rfbank_mode_t;
  localparam logic [3:0] RFBANK_BANK_NORMAL = 4'h0;
  localparam logic [3:0] RFBANK_BANK_F = 4'hF;
  localparam logic [3:0] RFBANK_BANK_D = 4'hD;
  localparam logic [3:0] RFBANK_GROUP_LOW = 4'h0;
  localparam logic [3:0] RFBANK_GROUP_NO_DIRECT = 4'hE;
  localparam logic [7:0] RFBANK_PORT_LAST = 8'h03;
  localparam logic [7:0] RFBANK_ADDR_POINTER = 8'hFD;
  localparam logic [7:0] RFBANK_ADDR_SP_HIGH = 8'hFE;
  localparam logic [7:0] RFBANK_ADDR_SP_LOW = 8'hFF;
  localparam logic [7:0] RFBANK_POINTER_RESET = 8'h00;
  localparam logic [7:0] RFBANK_SP_RESET = 8'h00;
  // Timer bank offsets.
  localparam logic [3:0] RFBANK_D_CTRL8 = 4'h0;
  localparam logic [3:0] RFBANK_D_CTRL_SHARED = 4'h1;
  localparam logic [3:0] RFBANK_D_CTRL16 = 4'h2;
  localparam logic [3:0] RFBANK_D_HOLD_FIRST = 4'h4;
  localparam logic [3:0] RFBANK_D_HOLD_LAST = 4'h7;
  localparam logic [3:0] RFBANK_D_CAPT_FIRST = 4'h8;
  localparam logic [3:0] RFBANK_D_CAPT_LAST = 4'hB;
  localparam logic [7:0] RFBANK_CTRL_RESET = 8'h00;
endpackage

/* File: rtl/rfbank_regfile.sv */
// Purpose: Register file with working groups, expanded banks and the stack pointer.
// Assumes: Core requests are one-cycle pulses on CLK; port pins are asynchronous.
// Notes: Every access is answered one cycle after the request.
`timescale 1ns/100ps
module rfbank_regfile
  import rfbank_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Core register access
  input wire logic CORE_RD,
  input wire logic CORE_WR,
  input wire logic [1:0] CORE_MODE,
  input wire logic [7:0] CORE_ADDR,
  input wire logic [7:0] CORE_WDATA,
  output logic [7:0] CORE_RDATA,
  output logic CORE_ACK,
  output logic CORE_REFUSED,
  // Core stack operations
  input wire logic STACK_PUSH,
  input wire logic STACK_POP,
  input wire logic STACK_INTERNAL,
  output logic [15:0] EXT_STACK_ADDR,
  output logic EXT_STACK_REQ,
  output logic EXT_STACK_WRITE,
  output logic [7:0] EXT_STACK_DATA,
  // Ports
  input wire logic [31:0] PORT_IN,
  output logic [31:0] PORT_OUT,
  input wire logic PORT0_ADDR_MODE,
  output logic [7:0] PORT0_ADDR_OUT,
  output logic PORT0_ADDR_STROBE,
  // Register pointer and timer bank
  output logic [7:0] REGISTER_POINTER,
  input wire logic [3:0] CAPTURE_LOAD,
  input wire logic [31:0] CAPTURE_DATA,
  output logic [7:0] TIMER8_CONTROL,
  output logic [7:0] TIMER_SHARED_CONTROL,
  output logic [7:0] TIMER16_CONTROL,
  output logic [31:0] TIMER_HOLD
);
  logic [7:0] mem [0:255];
  logic [31:0] port_meta;
  logic [31:0] port_sync;
  logic [7:0] stack_pointer_low;
  logic [7:0] stack_pointer_high;
  logic [7:0] eff_addr;
  logic [3:0] bank;
  logic access;
  logic refused;
  logic low_group;
  logic sel_d;
  logic sel_f;
  logic sel_none;
  logic sel_normal;
  logic wr_ok;
  logic [7:0] bank_d_rdata;
  logic [7:0] bank_f [0:15];
  logic [7:0] next_rdata;
  logic [15:0] sp_full;
  logic [7:0] sp_dec;
  logic [7:0] sp_inc;
  logic stack_op;

  //////////////////////////////////////////////////////////////////////////////
  // Address resolution.
  assign access = CORE_RD | CORE_WR;
  assign bank = REGISTER_POINTER[3:0];
  assign eff_addr = (CORE_MODE == RFBANK_MODE_WORKING) ?
                    {REGISTER_POINTER[7:4], CORE_ADDR[3:0]} : CORE_ADDR;
  assign refused = (CORE_MODE == RFBANK_MODE_DIRECT) &&
                   (CORE_ADDR[7:4] == RFBANK_GROUP_NO_DIRECT);
  // only the lowest sixteen are swapped
  assign low_group = (eff_addr[7:4] == RFBANK_GROUP_LOW);
  assign sel_d = low_group && (bank == RFBANK_BANK_D);
  assign sel_f = low_group && (bank == RFBANK_BANK_F);
  assign sel_none = low_group && (bank != RFBANK_BANK_NORMAL) && !sel_d && !sel_f;
  // bank zero keeps the normal file
  assign sel_normal = !low_group || (bank == RFBANK_BANK_NORMAL);
  assign wr_ok = CORE_WR && !refused && !sel_none;

  //////////////////////////////////////////////////////////////////////////////
  // Port pins are resynchronised before any read sees them.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      port_meta <= 32'h0000_0000;
      port_sync <= 32'h0000_0000;
    end else begin
      port_meta <= PORT_IN;
      port_sync <= port_meta;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PORT_OUT <= 32'h0000_0000;
    end else if (wr_ok && sel_normal && eff_addr <= RFBANK_PORT_LAST) begin
      PORT_OUT[eff_addr[1:0]*8 +: 8] <= CORE_WDATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      REGISTER_POINTER <= RFBANK_POINTER_RESET;
    end else if (wr_ok && sel_normal && eff_addr == RFBANK_ADDR_POINTER) begin
      REGISTER_POINTER <= CORE_WDATA;
    end
  end

  always_ff @(posedge CLK) begin
    if (wr_ok && sel_f) begin
      bank_f[eff_addr[3:0]] <= CORE_WDATA;
    end
  end

  rfbank_timer_bank u_timer_bank (
    .clk(CLK),
    .rst(RST),
    .wr(wr_ok && sel_d),
    .addr(eff_addr[3:0]),
    .wdata(CORE_WDATA),
    .rdata(bank_d_rdata),
    .capture_load(CAPTURE_LOAD),
    .capture_data(CAPTURE_DATA),
    .ctrl8(TIMER8_CONTROL),
    .ctrl_shared(TIMER_SHARED_CONTROL),
    .ctrl16(TIMER16_CONTROL),
    .hold(TIMER_HOLD)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Stack.
  assign stack_op = STACK_PUSH | STACK_POP;
  assign sp_full = {stack_pointer_high, stack_pointer_low};
  assign sp_dec = stack_pointer_low - 8'h01;
  assign sp_inc = stack_pointer_low + 8'h01;

  // general and control storage; internal pushes win over a core write.
  always_ff @(posedge CLK) begin
    if (STACK_PUSH && STACK_INTERNAL) begin
      mem[sp_dec] <= CORE_WDATA;
    end else if (wr_ok && sel_normal && eff_addr > RFBANK_PORT_LAST) begin
      mem[eff_addr] <= CORE_WDATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      stack_pointer_low <= RFBANK_SP_RESET;
      stack_pointer_high <= RFBANK_SP_RESET;
    end else if (STACK_INTERNAL && stack_op) begin
      stack_pointer_low <= STACK_PUSH ? sp_dec : sp_inc;
    end else if (!STACK_INTERNAL && stack_op) begin
      // both bytes form the external pointer
      {stack_pointer_high, stack_pointer_low} <= STACK_PUSH ? sp_full - 16'h0001 :
                                                 sp_full + 16'h0001;
    end else if (wr_ok && sel_normal) begin
      if (eff_addr == RFBANK_ADDR_SP_LOW) stack_pointer_low <= CORE_WDATA;
      if (eff_addr == RFBANK_ADDR_SP_HIGH) stack_pointer_high <= CORE_WDATA;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      EXT_STACK_ADDR <= 16'h0000;
      EXT_STACK_REQ <= 1'b0;
      EXT_STACK_WRITE <= 1'b0;
      EXT_STACK_DATA <= 8'h00;
    end else begin
      EXT_STACK_REQ <= stack_op && !STACK_INTERNAL;
      EXT_STACK_WRITE <= STACK_PUSH && !STACK_INTERNAL;
      if (stack_op && !STACK_INTERNAL) begin
        EXT_STACK_ADDR <= STACK_PUSH ? sp_full - 16'h0001 : sp_full;
        EXT_STACK_DATA <= CORE_WDATA;
      end
    end
  end

  // high byte leaks to Port 0 on internal stack access
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      PORT0_ADDR_OUT <= 8'h00;
      PORT0_ADDR_STROBE <= 1'b0;
    end else begin
      PORT0_ADDR_STROBE <= stack_op && STACK_INTERNAL && PORT0_ADDR_MODE;
      if (stack_op && STACK_INTERNAL && PORT0_ADDR_MODE) begin
        PORT0_ADDR_OUT <= stack_pointer_high;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path.
  always_comb begin
    next_rdata = 8'h00;
    if (STACK_POP && STACK_INTERNAL) begin
      next_rdata = mem[stack_pointer_low];
    end else if (refused || sel_none) begin
      next_rdata = 8'h00;
    end else if (sel_d) begin
      next_rdata = bank_d_rdata;
    end else if (sel_f) begin
      next_rdata = bank_f[eff_addr[3:0]];
    end else if (eff_addr <= RFBANK_PORT_LAST) begin
      next_rdata = port_sync[eff_addr[1:0]*8 +: 8];
    end else if (eff_addr == RFBANK_ADDR_POINTER) begin
      next_rdata = REGISTER_POINTER;
    end else if (eff_addr == RFBANK_ADDR_SP_LOW) begin
      next_rdata = stack_pointer_low;
    end else if (eff_addr == RFBANK_ADDR_SP_HIGH) begin
      next_rdata = stack_pointer_high;
    end else begin
      next_rdata = mem[eff_addr];
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      CORE_RDATA <= 8'h00;
      CORE_ACK <= 1'b0;
      CORE_REFUSED <= 1'b0;
    end else begin
      CORE_ACK <= access || (STACK_POP && STACK_INTERNAL);
      CORE_REFUSED <= access && refused;
      if (CORE_RD || (STACK_POP && STACK_INTERNAL)) begin
        CORE_RDATA <= next_rdata;
      end
    end
  end
endmodule // rfbank_regfile

/* File: rtl/rfbank_timer_bank.sv */
// Purpose: Register storage of expanded bank D for the counter/timers.
// Assumes: Capture strobes come from counter logic on the same clock.
// Notes: Read data is combinational; the caller registers it.
`timescale 1ns/100ps
module rfbank_timer_bank
  import rfbank_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Access from the address decoder
  input wire logic wr,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  // Capture inputs, one strobe per capture byte
  input wire logic [3:0] capture_load,
  input wire logic [31:0] capture_data,
  // Register contents
  output logic [7:0] ctrl8,
  output logic [7:0] ctrl_shared,
  output logic [7:0] ctrl16,
  output logic [31:0] hold
);
  logic [31:0] capture;
  logic [1:0] idx;

  assign idx = addr[1:0];

  //////////////////////////////////////////////////////////////////////////////
  // control registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl8 <= RFBANK_CTRL_RESET;
      ctrl_shared <= RFBANK_CTRL_RESET;
      ctrl16 <= RFBANK_CTRL_RESET;
    end else if (wr) begin
      if (addr == RFBANK_D_CTRL8) ctrl8 <= wdata;
      if (addr == RFBANK_D_CTRL_SHARED) ctrl_shared <= wdata;
      if (addr == RFBANK_D_CTRL16) ctrl16 <= wdata;
    end
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_byte
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          hold[g*8 +: 8] <= RFBANK_CTRL_RESET;
        end else if (wr && addr >= RFBANK_D_HOLD_FIRST && addr <= RFBANK_D_HOLD_LAST
                     && idx == 2'(g)) begin
          hold[g*8 +: 8] <= wdata;
        end
      end
      // Capture bytes ignore core writes; only the counters load them.
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          capture[g*8 +: 8] <= RFBANK_CTRL_RESET;
        end else if (capture_load[g]) begin
          capture[g*8 +: 8] <= capture_data[g*8 +: 8];
        end
      end
    end
  endgenerate

  always_comb begin
    rdata = 8'h00;
    if (addr == RFBANK_D_CTRL8) rdata = ctrl8;
    else if (addr == RFBANK_D_CTRL_SHARED) rdata = ctrl_shared;
    else if (addr == RFBANK_D_CTRL16) rdata = ctrl16;
    else if (addr >= RFBANK_D_HOLD_FIRST && addr <= RFBANK_D_HOLD_LAST) rdata = hold[idx*8 +: 8];
    else if (addr >= RFBANK_D_CAPT_FIRST && addr <= RFBANK_D_CAPT_LAST) rdata = capture[idx*8 +: 8];
  end
endmodule // rfbank_timer_bank

/* File: testbench/rfbank_core_model.sv */
// Purpose: Core-side model issuing register and stack requests.
// Assumes: Requests are one-cycle pulses launched at the falling edge.
// Notes: One idle cycle follows each request.
`timescale 1ns/100ps
module rfbank_core_model
  import rfbank_pkg::*;
(
  // Clock
  input wire logic clk,
  // Request lines
  output logic rd,
  output logic wr,
  output logic [1:0] mode,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic push,
  output logic pop
);
  initial begin
    {rd, wr, push, pop, mode, addr, wdata} = 22'h0;
  end
  task automatic op(input logic [1:0] kind, input logic [1:0] m, input logic [7:0] a,
                    input logic [7:0] d, input logic [1:0] stk);
    @(negedge clk);
    {rd, wr} = kind;
    {push, pop} = stk;
    mode = m;
    addr = a;
    wdata = d;
    @(negedge clk);
    {rd, wr, push, pop} = 4'h0;
    // Released address and data lines flip so that no stale value can pass for a live one.
    addr = ~a;
    wdata = ~d;
  endtask
endmodule // rfbank_core_model

/* File: testbench/rfbank_regfile_assertions.sv */
// Purpose: Concurrent checks on the register file ports.
// Assumes: Core and stack requests are one-cycle pulses on CLK.
// Notes: Bound to every register file instance at the foot of this file.
`timescale 1ns/100ps
module rfbank_regfile_assertions
  import rfbank_pkg::*;
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Core side
  input wire logic CORE_RD,
  input wire logic CORE_WR,
  input wire logic [1:0] CORE_MODE,
  input wire logic [7:0] CORE_ADDR,
  input wire logic [7:0] CORE_WDATA,
  input wire logic [7:0] CORE_RDATA,
  input wire logic CORE_ACK,
  input wire logic CORE_REFUSED,
  input wire logic STACK_PUSH,
  input wire logic STACK_POP,
  input wire logic STACK_INTERNAL,
  // Results
  input wire logic EXT_STACK_REQ,
  input wire logic EXT_STACK_WRITE,
  input wire logic [31:0] PORT_OUT,
  input wire logic PORT0_ADDR_MODE,
  input wire logic PORT0_ADDR_STROBE,
  input wire logic [7:0] REGISTER_POINTER,
  input wire logic [7:0] TIMER8_CONTROL,
  input wire logic [7:0] TIMER_SHARED_CONTROL
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);
  logic dir;
  logic bank_ok;
  logic calm;
  logic [7:0] eff;
  assign dir = (CORE_MODE == RFBANK_MODE_DIRECT);
  // Short addresses sit inside the group named by the pointer's upper nibble.
  assign eff = (CORE_MODE == RFBANK_MODE_WORKING) ? {REGISTER_POINTER[7:4], CORE_ADDR[3:0]} :
               CORE_ADDR;
  assign bank_ok = REGISTER_POINTER[3:0] inside {RFBANK_BANK_NORMAL, RFBANK_BANK_D, RFBANK_BANK_F};
  // Stack traffic may override a core access, so those cycles are left out.
  assign calm = !STACK_PUSH && !STACK_POP;
  ////////////////////////////////////////////////////////////////////////////////
  property p_ack; (CORE_RD || CORE_WR) |=> CORE_ACK; endproperty
  a_ack: assert property (p_ack) else $error("access not acknowledged");
  property p_refuse;
    CORE_RD && dir && CORE_ADDR[7:4] == RFBANK_GROUP_NO_DIRECT |=> CORE_REFUSED && CORE_RDATA == 8'h00;
  endproperty
  a_refuse: assert property (p_refuse) else $error("direct access to group E passed");
  property p_indirect_ok; (CORE_RD || CORE_WR) && !dir |=> !CORE_REFUSED; endproperty
  a_indirect_ok: assert property (p_indirect_ok) else $error("indirect access refused");
  property p_pointer;
    CORE_WR && dir && CORE_ADDR == RFBANK_ADDR_POINTER && calm |=> REGISTER_POINTER == $past(CORE_WDATA);
  endproperty
  a_pointer: assert property (p_pointer) else $error("pointer not written");
  property p_shared_rd;
    CORE_RD && dir && CORE_ADDR == 8'h01 && REGISTER_POINTER[3:0] == RFBANK_BANK_D && calm
      |=> CORE_RDATA == $past(TIMER_SHARED_CONTROL);
  endproperty
  a_shared_rd: assert property (p_shared_rd) else $error("bank D read wrong");
  property p_ctl8_wr;
    CORE_WR && eff == 8'h00 && REGISTER_POINTER[3:0] == RFBANK_BANK_D && calm
      |=> TIMER8_CONTROL == $past(CORE_WDATA);
  endproperty
  a_ctl8_wr: assert property (p_ctl8_wr) else $error("bank D write lost");
  property p_unimpl;
    CORE_RD && dir && CORE_ADDR[7:4] == RFBANK_GROUP_LOW && !bank_ok && calm
      |=> CORE_RDATA == 8'h00 && !CORE_REFUSED;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("missing bank not zero");
  property p_port_wr;
    CORE_WR && dir && CORE_ADDR == 8'h01 && REGISTER_POINTER[3:0] == RFBANK_BANK_NORMAL && calm
      |=> PORT_OUT[15:8] == $past(CORE_WDATA);
  endproperty
  a_port_wr: assert property (p_port_wr) else $error("port latch not written");
  property p_p0; STACK_PUSH && STACK_INTERNAL && PORT0_ADDR_MODE |=> PORT0_ADDR_STROBE; endproperty
  a_p0: assert property (p_p0) else $error("high stack byte not on port 0");
  property p_ext; STACK_PUSH && !STACK_INTERNAL |=> EXT_STACK_REQ && EXT_STACK_WRITE; endproperty
  a_ext: assert property (p_ext) else $error("external push not issued");
  c_refuse: cover property (CORE_REFUSED);
  c_p0: cover property (PORT0_ADDR_STROBE);
  c_ext: cover property (EXT_STACK_REQ);
endmodule // rfbank_regfile_assertions

bind rfbank_regfile rfbank_regfile_assertions u_chk (.CLK, .RST, .CORE_RD, .CORE_WR,
  .CORE_MODE, .CORE_ADDR, .CORE_WDATA, .CORE_RDATA, .CORE_ACK, .CORE_REFUSED, .STACK_PUSH,
  .STACK_POP, .STACK_INTERNAL, .EXT_STACK_REQ, .EXT_STACK_WRITE, .PORT_OUT, .PORT0_ADDR_MODE,
  .PORT0_ADDR_STROBE, .REGISTER_POINTER, .TIMER8_CONTROL, .TIMER_SHARED_CONTROL);

/* File: testbench/tb_register_file_bank_addressing.sv */
// Purpose: Self-checking bench for the register file bank addressing.
// Assumes: Inputs change at the falling edge of CLK.
// Notes: Read results are queued as notes and compared when CORE_ACK shows.
`timescale 1ns/100ps
module tb_register_file_bank_addressing
  import rfbank_pkg::*;
;
  logic CLK = 1'h0;
  logic RST = 1'h1;
  logic rd, wr, push, pop, stk_int, p0_mode, ack, refused, strobe, ext_req, ext_wr;
  logic [1:0] mode;
  logic [3:0] cap_load;
  logic [7:0] addr, wdata, rdata, rp, t8, tsh, t16, p0_out, ext_data, d, e;
  logic [15:0] ext_addr;
  logic [31:0] port_in, port_out, cap_data, hold;
  logic [9:0] note;
  logic [9:0] notes [$];
  int miscompares, check_count, cycles;
  wire logic [23:0] ctl_all = {t16, tsh, t8};
  always #2.5 CLK = ~CLK;
  rfbank_core_model u_core (.clk(CLK), .rd(rd), .wr(wr), .mode(mode), .addr(addr),
    .wdata(wdata), .push(push), .pop(pop));
  rfbank_regfile u_dut (.CLK(CLK), .RST(RST), .CORE_RD(rd), .CORE_WR(wr), .CORE_MODE(mode),
    .CORE_ADDR(addr), .CORE_WDATA(wdata), .CORE_RDATA(rdata), .CORE_ACK(ack),
    .CORE_REFUSED(refused), .STACK_PUSH(push), .STACK_POP(pop), .STACK_INTERNAL(stk_int),
    .EXT_STACK_ADDR(ext_addr), .EXT_STACK_REQ(ext_req), .EXT_STACK_WRITE(ext_wr),
    .EXT_STACK_DATA(ext_data), .PORT_IN(port_in), .PORT_OUT(port_out),
    .PORT0_ADDR_MODE(p0_mode), .PORT0_ADDR_OUT(p0_out), .PORT0_ADDR_STROBE(strobe),
    .REGISTER_POINTER(rp), .CAPTURE_LOAD(cap_load), .CAPTURE_DATA(cap_data),
    .TIMER8_CONTROL(t8), .TIMER_SHARED_CONTROL(tsh), .TIMER16_CONTROL(t16), .TIMER_HOLD(hold));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_value(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic r, input logic [1:0] m, input logic [7:0] a,
                     input logic [7:0] dd, input logic [8:0] exp);
    notes.push_back({r, exp});
    u_core.op({r, !r}, m, a, dd, 2'h0);
  endtask
  task automatic wrd(input logic [7:0] a, input logic [7:0] dd);
    acc(1'h0, RFBANK_MODE_DIRECT, a, dd, 9'h000);
  endtask
  task automatic rdd(input logic [7:0] a, input logic [8:0] exp);
    acc(1'h1, RFBANK_MODE_DIRECT, a, 8'h00, exp);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(negedge CLK) begin
    if (ack === 1'h1) begin
      check_value("pending note", 32'h1, notes.size() != 0);
      note = notes.pop_front();
      check_value("refused", note[8], refused);
      if (note[9]) check_value("read data", note[7:0], rdata);
    end
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(51013));
    {stk_int, p0_mode, cap_load} = 6'h00;
    port_in = $urandom();
    cap_data = $urandom();
    repeat (20) @(negedge CLK);
    RST = 1'h0;
    wrd(RFBANK_ADDR_POINTER, 8'h0D);
    check_value("pointer", 32'h0D, rp);
    cap_load = 4'hF;
    @(negedge CLK);
    cap_load = 4'h0;
    for (int i = 0; i < 13; i++) begin
      d = $urandom();
      acc(1'h0, RFBANK_MODE_WORKING, i[7:0], d, 9'h000);
      e = (i == 3 || i == 12) ? 8'h00 : (i < 8) ? d : cap_data[i[1:0] * 8 +: 8];
      rdd(i[7:0], {1'h0, e});
      if (i < 3) check_value("timer control", d, ctl_all[i * 8 +: 8]);
      if (i > 3 && i < 8) check_value("timer hold", d, hold[i[1:0] * 8 +: 8]);
    end
    wrd(RFBANK_ADDR_POINTER, 8'h03);
    wrd(8'h01, 8'hA5);
    rdd(8'h01, 9'h000);
    check_value("port latch", 32'h0, port_out);
    wrd(RFBANK_ADDR_POINTER, 8'h00);
    d = $urandom();
    wrd(8'h01, d);
    check_value("port latch", {16'h0000, d, 8'h00}, port_out);
    rdd(8'h02, {1'h0, port_in[23:16]});
    wrd(RFBANK_ADDR_POINTER, 8'hE0);
    acc(1'h0, RFBANK_MODE_WORKING, 8'h05, 8'h3C, 9'h000);
    acc(1'h0, RFBANK_MODE_DIRECT, 8'hE5, d, 9'h100);
    rdd(8'hE5, 9'h100);
    acc(1'h1, RFBANK_MODE_INDIRECT, 8'hE5, 8'h00, 9'h03C);
    wrd(RFBANK_ADDR_POINTER, 8'h0F);
    wrd(8'h20, d);
    wrd(8'h05, 8'h96);
    rdd(8'h05, 9'h096);
    wrd(RFBANK_ADDR_POINTER, 8'h00);
    rdd(8'h20, {1'h0, d});
    wrd(RFBANK_ADDR_SP_LOW, 8'h80);
    wrd(RFBANK_ADDR_SP_HIGH, 8'h5A);
    {stk_int, p0_mode} = 2'h3;
    d = $urandom();
    u_core.op(2'h0, RFBANK_MODE_DIRECT, 8'h00, d, 2'h2);
    check_value("port0 strobe", 32'h1, strobe);
    check_value("port0 byte", 32'h5A, p0_out);
    rdd(RFBANK_ADDR_SP_LOW, 9'h07F);
    notes.push_back({2'h2, d});
    u_core.op(2'h0, RFBANK_MODE_DIRECT, 8'h00, 8'h00, 2'h1);
    rdd(RFBANK_ADDR_SP_LOW, 9'h080);
    stk_int = 1'h0;
    u_core.op(2'h0, RFBANK_MODE_DIRECT, 8'h00, d, 2'h2);
    check_value("ext push", {15'h0000, 1'h1, 16'h5A7F}, {15'h0000, ext_wr, ext_addr});
    check_value("ext data", d, ext_data);
    u_core.op(2'h0, RFBANK_MODE_DIRECT, 8'h00, 8'h00, 2'h1);
    check_value("ext pop", {2'h2, 16'h5A7F}, {ext_req, ext_wr, ext_addr});
    repeat (2) @(negedge CLK);
    check_value("notes left", 32'h0, notes.size());
    tally_and_finish();
  end
endmodule // tb_register_file_bank_addressing
